// ---- design/mpwm_ch_if.sv ----
// Purpose: Link between the register block and one channel counter
// Assumes: Single clock domain
// Notes: ctrl drives set-up and events, chan returns count state
`timescale 1ns/1ps
interface mpwm_ch_if;
  import mpwm_pkg::*;
  logic tick;
  logic run;
  logic start;
  logic trig;
  logic one_cnt;
  mpwm_cnt_t data;
  mpwm_cnt_t cnt;
  logic irq;
  logic act;
  modport ctrl (output tick, run, start, trig, one_cnt, data, input cnt, irq, act);
  modport chan (input tick, run, start, trig, one_cnt, data, output cnt, irq, act);
endinterface

// ---- design/mpwm_chan.sv ----
// Purpose: One down counter in interval or one-count mode
// Assumes: Ticks, triggers and start are one-cycle pulses
// Notes: Output phase act drives the slave PWM level
`timescale 1ns/1ps
`include "mpwm_defs.svh"
module mpwm_chan
  import mpwm_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Register block side
  mpwm_ch_if.chan ch
);
  mpwm_ch_st_t st_q;
  mpwm_cnt_t cnt_q;
  logic irq_q;
  logic act_q;

  assign ch.cnt = cnt_q;
  assign ch.irq = irq_q;
  assign ch.act = act_q;

  // Sequencer, counter and output phase
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_q <= CH_STOP;
      cnt_q <= `MPWM_IDLE_CNT;
      irq_q <= 1'b0;
      act_q <= 1'b0;
    end else if (!ch.run) begin
      st_q <= CH_STOP;
      irq_q <= 1'b0;
      act_q <= 1'b0;
    end else begin
      irq_q <= 1'b0;
      case (st_q)
        CH_STOP: begin
          if (ch.start && ch.one_cnt) begin
            st_q <= CH_WAIT; // R15
            cnt_q <= `MPWM_IDLE_CNT;
          end else if (ch.start) begin
            st_q <= CH_RUN; // R17
            cnt_q <= ch.data; // R14
          end
        end
        CH_WAIT: begin
          if (ch.trig) begin
            st_q <= CH_ARM; // R15
          end
        end
        CH_ARM: begin
          if (ch.tick) begin
            cnt_q <= ch.data;
            act_q <= (ch.data != `MPWM_ZERO_CNT); // R16
            st_q <= CH_RUN;
          end
        end
        CH_RUN: begin
          if (ch.one_cnt && ch.trig) begin
            st_q <= CH_ARM; // R18
          end else if (ch.tick && cnt_q == `MPWM_ZERO_CNT) begin
            irq_q <= 1'b1;
            if (ch.one_cnt) begin
              cnt_q <= `MPWM_IDLE_CNT; // R15
              st_q <= CH_WAIT;
            end else begin
              cnt_q <= ch.data; // R14
            end
          end else if (ch.tick) begin
            cnt_q <= cnt_q - `MPWM_STEP;
            if (cnt_q == `MPWM_STEP) begin
              act_q <= 1'b0; // R16
            end
          end
        end
        default: begin
          st_q <= CH_STOP;
        end
      endcase
    end
  end

  // ==========================================
  // Checks
  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  reload_a: assert property ((ch.run && st_q == CH_RUN && !ch.one_cnt && ch.tick && cnt_q == `MPWM_ZERO_CNT) // R14
    |=> (irq_q && cnt_q == $past(ch.data))) else $error("interval reload missed");
  idle_a: assert property ((irq_q && ch.one_cnt) |-> (cnt_q == `MPWM_IDLE_CNT && st_q == CH_WAIT)) // R15
    else $error("one-count did not idle");
  arm_act_a: assert property ((ch.run && st_q == CH_ARM && ch.tick && ch.data != `MPWM_ZERO_CNT) // R16
    |=> (act_q && st_q == CH_RUN)) else $error("output not active after load");
  arm_wait_a: assert property ((ch.run && st_q == CH_WAIT && ch.trig) |=> st_q == CH_ARM) // R15
    else $error("trigger not taken");
  period_c: cover property (irq_q && !ch.one_cnt);
  duty_c: cover property ($fell(act_q) && ch.run);
endmodule

// ---- design/mpwm_defs.svh ----
// Purpose: Offsets, field positions and reset values of the PWM unit
// Assumes: Byte addresses on the Avalon-MM bus, one word per register
// Notes: Data and mode registers are arrays at a 4-byte stride
`ifndef MPWM_DEFS_SVH
`define MPWM_DEFS_SVH

// ==========================================
// Register byte offsets
`define MPWM_A_PWR 8'h00
`define MPWM_A_PRESC 8'h04
`define MPWM_A_MODE0 8'h08
`define MPWM_A_DATA0 8'h14
`define MPWM_A_OUTVAL 8'h20
`define MPWM_A_OUTEN 8'h24
`define MPWM_A_OUTLVL 8'h28
`define MPWM_A_OUTMODE 8'h2c
`define MPWM_A_START 8'h30
`define MPWM_A_STATUS 8'h34
`define MPWM_A_STOP 8'h38
`define MPWM_A_COUNT 8'h3c
`define MPWM_A_IRQST 8'h40
`define MPWM_A_IRQCLR 8'h44
`define MPWM_A_IRQEN 8'h48
`define MPWM_A_PORT 8'h4c

// ==========================================
// Field positions
`define MPWM_F_CLKSEL 0
`define MPWM_F_ONECNT 1
`define MPWM_F_PRESC_B 4
`define MPWM_F_LATCH 4

// ==========================================
// Reset values and counter marks
`define MPWM_R_MODE 2'h0
`define MPWM_R_DATA 16'h0000
`define MPWM_R_BITS 3'h0
`define MPWM_R_PM 3'h7
`define MPWM_R_PRESC 8'h00
`define MPWM_IDLE_CNT 16'hffff
`define MPWM_ZERO_CNT 16'h0000
`define MPWM_STEP 16'h0001

`endif

// ---- design/mpwm_pkg.sv ----
// Purpose: Shared types of the PWM unit
// Assumes: Nothing beyond the defs header
// Notes: States follow a Gray path stop-wait-arm-run
package mpwm_pkg;
  // Channel sequencer states
  typedef enum logic [1:0] {
    CH_STOP = 2'b00,
    CH_WAIT = 2'b01,
    CH_ARM = 2'b11,
    CH_RUN = 2'b10
  } mpwm_ch_st_t;
  // Counter word
  typedef logic [15:0] mpwm_cnt_t;
endpackage

// ---- design/mpwm_presc.sv ----
// Purpose: Operating clock tick generator for both clock sources
// Assumes: Ticks are one-cycle enables on the system clock
// Notes: Divider is held cleared while the unit is powered off
`timescale 1ns/1ps
`include "mpwm_defs.svh"
module mpwm_presc (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Control
  input wire logic en,
  input wire logic [7:0] presc,
  // Ticks
  output logic op_clock_a,
  output logic op_clock_b
);
  logic [15:0] div_q;

  // Tick when the low n divider bits are all ones
  function automatic logic due(input logic [15:0] d, input logic [3:0] n);
    logic [15:0] m;
    m = (16'h0001 << n) - 16'h0001;
    due = ((d & m) == m);
  endfunction

  // Free running divider
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      div_q <= 16'h0000;
    end else if (!en) begin
      div_q <= 16'h0000;
    end else begin
      div_q <= div_q + 16'h0001;
    end
  end

  // Registered ticks, silent when powered off
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      op_clock_a <= 1'b0;
      op_clock_b <= 1'b0;
    end else begin
      op_clock_a <= en & due(div_q, presc[3:0]);
      op_clock_b <= en & due(div_q, presc[`MPWM_F_PRESC_B +: 4]);
    end
  end
endmodule

// ---- design/mpwm_top.sv ----
// Purpose: Register block and pin control of a three channel PWM unit
// Assumes: Avalon-MM slave with one wait state on every access
// Notes: Channel 0 is the period master, channels 1 and 2 the duty slaves
`timescale 1ns/1ps
`include "mpwm_defs.svh"

// How it works
// R01: Master output value bit at 0 drives a low master output.
// R02: Master output enable at 0 keeps counting off the master output.
// R03: Output level bit has no effect on a master-mode channel.
// R04: Output mode bit 0 selects master output mode.
// R05: Output mode bit 1 makes the channel a duty output following its counter.
// R06: Powered off, the unit clock stops and register writes are ignored.
// R07: Power enable comes first; reads and writes blocked while it is 0.
// R08: Software picks each channel's clock source before configuring channels.
// R09: Software sets modes, period and duties while channels are stopped.
// R10: Writing slave output values while stopped only sets default levels.
// R11: Software enables slave outputs so counting may drive them.
// R12: With port bits cleared, each slave pin shows its output value bit.
// R13: Slave pins float while master and own output enables are clear.
// R14: Master counts down from period, interrupts at zero, reloads.
// R15: Slave loads duty on master interrupt, counts to zero, idles all ones.
// R16: Slave output goes active one tick after trigger, inactive at zero.
// R17: Start bits set enable status, start the master and self-clear.
// R18: Duty above period plus one yields a constant active output.
// R19: Software rewrites period and duties together right after a master interrupt.
module mpwm_top
  import mpwm_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Avalon-MM slave
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Timer pins
  output logic master_out_value,
  output logic master_out_value_oe,
  output logic slave1_pwm_out,
  output logic slave1_pwm_out_oe,
  output logic slave2_pwm_out,
  output logic slave2_pwm_out_oe,
  // Interrupt
  output logic irq
);
  logic ack_q;
  logic wr_en;
  logic unit_wr;
  logic pwr_q;
  logic [7:0] presc_q;
  logic [1:0] mode_q [3];
  mpwm_cnt_t data_q [3];
  logic [2:0] tov_q;
  logic [2:0] toe_q;
  logic [2:0] lvl_q;
  logic [2:0] omode_q;
  logic [2:0] te_q;
  logic [2:0] start_q;
  logic [2:0] ist_q;
  logic [2:0] ien_q;
  logic [2:0] pm_q;
  logic [2:0] latch_q;
  logic [31:0] readdata_q;
  logic [31:0] rd_mux;
  logic [2:0] ev;
  logic [2:0] act;
  mpwm_cnt_t cnt [3];
  logic op_clock_a;
  logic op_clock_b;
  logic [2:0] pin_lv;
  logic [2:0] pin_oe;

  // Word match on a byte offset
  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    hit = (a[7:2] == b[7:2]);
  endfunction

  // ==========================================
  // Bus handshake
  // One wait state, write and read data at the released edge
  assign waitrequest = (read | write) & ~ack_q;
  assign wr_en = write & ack_q;
  assign unit_wr = wr_en & pwr_q; // R06
  assign readdata = readdata_q;

  // Wait-state toggle
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (read | write) & ~ack_q;
    end
  end

  // ==========================================
  // Registers
  // Power enable, always reachable
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pwr_q <= 1'b0;
    end else if (wr_en && hit(address, `MPWM_A_PWR)) begin
      pwr_q <= writedata[0]; // R07
    end
  end

  // Set-up bits, held at reset values while powered off (port mask all ones, rest zero)
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      presc_q <= `MPWM_R_PRESC;
      toe_q <= `MPWM_R_BITS;
      lvl_q <= `MPWM_R_BITS;
      omode_q <= `MPWM_R_BITS;
      ien_q <= `MPWM_R_BITS;
      pm_q <= `MPWM_R_PM;
      latch_q <= `MPWM_R_BITS;
    end else if (!pwr_q) begin
      presc_q <= `MPWM_R_PRESC; // R06
      toe_q <= `MPWM_R_BITS;
      lvl_q <= `MPWM_R_BITS;
      omode_q <= `MPWM_R_BITS;
      ien_q <= `MPWM_R_BITS;
      pm_q <= `MPWM_R_PM;
      latch_q <= `MPWM_R_BITS;
    end else if (unit_wr) begin
      if (hit(address, `MPWM_A_PRESC)) begin
        presc_q <= writedata[7:0];
      end
      if (hit(address, `MPWM_A_OUTEN)) begin
        toe_q <= writedata[2:0];
      end
      if (hit(address, `MPWM_A_OUTLVL)) begin
        lvl_q <= writedata[2:0];
      end
      if (hit(address, `MPWM_A_OUTMODE)) begin
        omode_q <= writedata[2:0]; // R04 R05
      end
      if (hit(address, `MPWM_A_IRQEN)) begin
        ien_q <= writedata[2:0];
      end
      if (hit(address, `MPWM_A_PORT)) begin
        pm_q <= writedata[2:0];
        latch_q <= writedata[`MPWM_F_LATCH +: 3];
      end
    end
  end

  // Mode and data arrays, mode locked while running
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 3; i++) begin
        mode_q[i] <= `MPWM_R_MODE;
        data_q[i] <= `MPWM_R_DATA;
      end
    end else if (!pwr_q) begin
      for (int i = 0; i < 3; i++) begin
        mode_q[i] <= `MPWM_R_MODE;
        data_q[i] <= `MPWM_R_DATA;
      end
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (unit_wr && !te_q[i] && hit(address, `MPWM_A_MODE0 + 8'(4 * i))) begin
          mode_q[i] <= writedata[1:0];
        end
        if (unit_wr && hit(address, `MPWM_A_DATA0 + 8'(4 * i))) begin
          data_q[i] <= writedata[15:0];
        end
      end
    end
  end

  // Enable status and self-clearing start pulses
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      te_q <= `MPWM_R_BITS;
      start_q <= `MPWM_R_BITS;
    end else if (!pwr_q) begin
      te_q <= `MPWM_R_BITS;
      start_q <= `MPWM_R_BITS;
    end else if (unit_wr && hit(address, `MPWM_A_START)) begin
      te_q <= te_q | writedata[2:0]; // R17
      start_q <= writedata[2:0];
    end else if (unit_wr && hit(address, `MPWM_A_STOP)) begin
      te_q <= te_q & ~writedata[2:0];
      start_q <= `MPWM_R_BITS;
    end else begin
      start_q <= `MPWM_R_BITS; // R17
    end
  end

  // Output values: counting drives them only when enabled
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tov_q <= `MPWM_R_BITS;
    end else if (!pwr_q) begin
      tov_q <= `MPWM_R_BITS;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (toe_q[i] && te_q[i]) begin
          if (omode_q[i]) begin
            tov_q[i] <= act[i]; // R05
          end else if (ev[i]) begin
            tov_q[i] <= ~tov_q[i]; // R04
          end
        end else if (unit_wr && hit(address, `MPWM_A_OUTVAL)) begin
          tov_q[i] <= writedata[i]; // R02 R10
        end
      end
    end
  end

  // Sticky status, set wins over clear
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ist_q <= `MPWM_R_BITS;
    end else if (!pwr_q) begin
      ist_q <= `MPWM_R_BITS;
    end else if (unit_wr && hit(address, `MPWM_A_IRQCLR)) begin
      ist_q <= (ist_q & ~writedata[2:0]) | ev;
    end else begin
      ist_q <= ist_q | ev;
    end
  end

  assign irq = |(ist_q & ien_q);

  // Read mux, unit registers read zero while powered off
  always_comb begin
    rd_mux = 32'h00000000;
    if (hit(address, `MPWM_A_PWR)) begin
      rd_mux[0] = pwr_q;
    end else if (pwr_q) begin // R07
      for (int i = 0; i < 3; i++) begin
        if (hit(address, `MPWM_A_MODE0 + 8'(4 * i))) begin
          rd_mux[1:0] = mode_q[i];
        end
        if (hit(address, `MPWM_A_DATA0 + 8'(4 * i))) begin
          rd_mux[15:0] = data_q[i];
        end
      end
      if (hit(address, `MPWM_A_PRESC)) rd_mux[7:0] = presc_q;
      if (hit(address, `MPWM_A_OUTVAL)) rd_mux[2:0] = tov_q;
      if (hit(address, `MPWM_A_OUTEN)) rd_mux[2:0] = toe_q;
      if (hit(address, `MPWM_A_OUTLVL)) rd_mux[2:0] = lvl_q;
      if (hit(address, `MPWM_A_OUTMODE)) rd_mux[2:0] = omode_q;
      if (hit(address, `MPWM_A_STATUS)) rd_mux[2:0] = te_q;
      if (hit(address, `MPWM_A_COUNT)) rd_mux[15:0] = cnt[0];
      if (hit(address, `MPWM_A_IRQST)) rd_mux[2:0] = ist_q;
      if (hit(address, `MPWM_A_IRQEN)) rd_mux[2:0] = ien_q;
      if (hit(address, `MPWM_A_PORT)) rd_mux[6:0] = {latch_q, 1'b0, pm_q};
    end
  end

  // Read data captured in the wait cycle
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      readdata_q <= 32'h00000000;
    end else if (read && !ack_q) begin
      readdata_q <= rd_mux;
    end
  end

  // ==========================================
  // Counting
  mpwm_presc u_presc (
    .clock(clock),
    .rst(rst),
    .en(pwr_q),
    .presc(presc_q),
    .op_clock_a(op_clock_a),
    .op_clock_b(op_clock_b)
  );

  // Channel counters; the master interrupt triggers the slaves
  for (genvar i = 0; i < 3; i++) begin : g_ch
    mpwm_ch_if chi ();
    assign chi.tick = mode_q[i][`MPWM_F_CLKSEL] ? op_clock_b : op_clock_a;
    assign chi.run = te_q[i];
    assign chi.start = start_q[i];
    assign chi.trig = (i != 0) && ev[0]; // R15
    assign chi.one_cnt = mode_q[i][`MPWM_F_ONECNT];
    assign chi.data = data_q[i];
    assign cnt[i] = chi.cnt;
    assign ev[i] = chi.irq;
    assign act[i] = chi.act;
    mpwm_chan u_ch (
      .clock(clock),
      .rst(rst),
      .ch(chi.chan)
    );
  end

  // ==========================================
  // Pins
  // Level applies only in slave mode; port latch ors in
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      pin_lv[i] = (tov_q[i] ^ (lvl_q[i] & omode_q[i])) | latch_q[i]; // R01 R03
    end
  end

  // Slaves float until an output enable is set
  assign pin_oe[0] = ~pm_q[0];
  assign pin_oe[2:1] = ~pm_q[2:1] & (toe_q[2:1] | {2{toe_q[0]}}); // R12 R13

  assign master_out_value = pin_lv[0];
  assign master_out_value_oe = pin_oe[0];
  assign slave1_pwm_out = pin_lv[1];
  assign slave1_pwm_out_oe = pin_oe[1];
  assign slave2_pwm_out = pin_lv[2];
  assign slave2_pwm_out_oe = pin_oe[2];

  // ==========================================
  // Checks
  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  off_write_a: assert property ((!pwr_q && write) |=> ($stable(data_q[0]) && $stable(toe_q))) // R06
    else $error("write took effect while powered off");
  blocked_read_a: assert property ((read && ack_q && !pwr_q && !hit(address, `MPWM_A_PWR)) // R07
    |-> readdata == 32'h00000000) else $error("read not blocked");
  master_low_a: assert property ((!tov_q[0] && !latch_q[0] && !omode_q[0]) |-> !master_out_value) // R01
    else $error("master output not low");
  hold_value_a: assert property ((pwr_q && !toe_q[0] && !(write && hit(address, `MPWM_A_OUTVAL))) // R02
    |=> tov_q[0] == $past(tov_q[0])) else $error("master value moved by counting");
  level_ign_a: assert property (!omode_q[0] |-> master_out_value == (tov_q[0] | latch_q[0])) // R03
    else $error("level bit acted in master mode");
  slave_track_a: assert property ((pwr_q && omode_q[1] && toe_q[1] && te_q[1]) // R05
    |=> tov_q[1] == $past(act[1])) else $error("slave value not following counter");
  slave_hiz_a: assert property ((!toe_q[0] && !toe_q[1]) |-> !slave1_pwm_out_oe) // R13
    else $error("slave pin driven while disabled");
  slave_drive_a: assert property ((!pm_q[2] && toe_q[2]) |-> (slave2_pwm_out_oe // R12
    && slave2_pwm_out == ((tov_q[2] ^ (lvl_q[2] & omode_q[2])) | latch_q[2]))) else $error("slave pin wrong");
  start_set_a: assert property ((wr_en && pwr_q && hit(address, `MPWM_A_START) && writedata[0]) // R17
    |=> (te_q[0] && start_q[0]) ##1 !start_q[0]) else $error("start trigger wrong");
  pwm_c: cover property (te_q[1] && $rose(tov_q[1]));
  period_irq_c: cover property (te_q[0] && ev[0]);
  irq_c: cover property (irq && ist_q[2]);
endmodule

// ---- testbench/mpwm_top_tb.sv ----
// Purpose: Self-checking bench for the three channel PWM unit
// Assumes: One wait state per Avalon access, prescaler exponent 0 ticks every clock
// Notes: Period 4 gives five ticks; slave duties 2 and 7 (the latter saturates)
`timescale 1ns/1ps
`include "mpwm_defs.svh"
module mpwm_top_tb
  import mpwm_pkg::*;
;
  // ==========================================
  // Stimulus and observed signals
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [7:0] address = 8'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0000_0000;
  logic [31:0] readdata;
  logic waitrequest;
  logic master_out_value;
  logic master_out_value_oe;
  logic slave1_pwm_out;
  logic slave1_pwm_out_oe;
  logic slave2_pwm_out;
  logic slave2_pwm_out_oe;
  logic irq;
  int fail_count = 0;
  int n_compared = 0;
  int cycles = 0;
  int n;
  logic [31:0] rdat;

  // ==========================================
  // Device under test
  mpwm_top i_dut (
    .clock(clock),
    .rst(rst),
    .address(address),
    .read(read),
    .write(write),
    .writedata(writedata),
    .readdata(readdata),
    .waitrequest(waitrequest),
    .master_out_value(master_out_value),
    .master_out_value_oe(master_out_value_oe),
    .slave1_pwm_out(slave1_pwm_out),
    .slave1_pwm_out_oe(slave1_pwm_out_oe),
    .slave2_pwm_out(slave2_pwm_out),
    .slave2_pwm_out_oe(slave2_pwm_out_oe),
    .irq(irq)
  );

  // ==========================================
  // Clock and hang guard
  always #25 clock = ~clock;

  // Cuts a hung run short
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fail_count = fail_count + 1;
      $display("unexpected at %0t: run timed out", $time);
      complete_run();
    end
  end

  // ==========================================
  // Tasks
  // Verdict and end of run
  task complete_run();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Compare one value with its expectation
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared = n_compared + 1;
    if (seen !== exp) begin
      fail_count = fail_count + 1;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Avalon write, held until waitrequest is sampled low
  task bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    address <= a;
    writedata <= d;
    write <= 1'b1;
    @(posedge clock);
    while (waitrequest !== 1'b0) @(posedge clock);
    write <= 1'b0;
  endtask

  // Avalon read, data taken at the edge where waitrequest is low
  task bus_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    address <= a;
    read <= 1'b1;
    @(posedge clock);
    while (waitrequest !== 1'b0) @(posedge clock);
    d = readdata;
    read <= 1'b0;
  endtask

  // Read and compare
  task rd_chk(input logic [7:0] a, input logic [31:0] exp);
    bus_rd(a, rdat);
    chk(rdat, exp);
  endtask

  // Pin levels and enables, settled at the falling edge
  task pins_chk(input logic [5:0] exp);
    @(negedge clock);
    chk({26'h0, master_out_value, master_out_value_oe, slave1_pwm_out, slave1_pwm_out_oe,
         slave2_pwm_out, slave2_pwm_out_oe}, {26'h0, exp});
  endtask

  // Selects one output pin
  function automatic logic pick(input int sel);
    if (sel == 1) begin
      return slave1_pwm_out;
    end else if (sel == 2) begin
      return slave2_pwm_out;
    end
    return master_out_value;
  endfunction

  // High cycles over ten periods, counted from a rising edge
  task high_count(input int sel, output int cnt);
    int k;
    cnt = 0;
    k = 0;
    @(negedge clock);
    while (pick(sel) !== 1'b0 && k < 100) begin
      @(negedge clock);
      k++;
    end
    while (pick(sel) !== 1'b1 && k < 200) begin
      @(negedge clock);
      k++;
    end
    for (int i = 0; i < 50; i++) begin
      cnt += (pick(sel) === 1'b1);
      @(negedge clock);
    end
  endtask

  // ==========================================
  // Main sequence
  initial begin
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    pins_chk(6'b000000);
    chk({31'h0, irq}, 32'h0000_0000);
    // Unit unpowered: writes dropped, reads blocked
    bus_wr(`MPWM_A_PRESC, 32'h0000_00ff);
    bus_wr(`MPWM_A_OUTEN, 32'h0000_0007);
    rd_chk(`MPWM_A_PRESC, 32'h0000_0000);
    bus_wr(`MPWM_A_PWR, 32'h0000_0001);
    rd_chk(`MPWM_A_PWR, 32'h0000_0001);
    rd_chk(`MPWM_A_OUTEN, 32'h0000_0000);
    rd_chk(`MPWM_A_STATUS, 32'h0000_0000);
    rd_chk(8'hfc, 32'h0000_0000);
    // Channel set-up while stopped
    bus_wr(`MPWM_A_PRESC, 32'h0000_0000);
    bus_wr(`MPWM_A_MODE0, 32'h0000_0000);
    bus_wr(`MPWM_A_MODE0 + 8'h04, 32'h0000_0002);
    bus_wr(`MPWM_A_MODE0 + 8'h08, 32'h0000_0002);
    bus_wr(`MPWM_A_DATA0, 32'h0000_0004);
    bus_wr(`MPWM_A_DATA0 + 8'h04, 32'h0000_0002);
    bus_wr(`MPWM_A_DATA0 + 8'h08, 32'h0000_0007);
    rd_chk(`MPWM_A_MODE0 + 8'h04, 32'h0000_0002);
    bus_wr(`MPWM_A_OUTMODE, 32'h0000_0006);
    rd_chk(`MPWM_A_OUTMODE, 32'h0000_0006);
    bus_wr(`MPWM_A_OUTLVL, 32'h0000_0001);
    bus_wr(`MPWM_A_OUTEN, 32'h0000_0000);
    bus_wr(`MPWM_A_OUTVAL, 32'h0000_0006);
    pins_chk(6'b001010);
    bus_wr(`MPWM_A_PORT, 32'h0000_0000);
    pins_chk(6'b011010);
    bus_wr(`MPWM_A_OUTVAL, 32'h0000_0002);
    pins_chk(6'b011000);
    bus_wr(`MPWM_A_OUTEN, 32'h0000_0006);
    pins_chk(6'b011101);
    // Start master and both slaves together
    bus_wr(`MPWM_A_START, 32'h0000_0007);
    rd_chk(`MPWM_A_STATUS, 32'h0000_0007);
    rd_chk(`MPWM_A_START, 32'h0000_0000);
    bus_rd(`MPWM_A_COUNT, rdat);
    chk({31'h0, rdat <= 32'd4}, 32'h0000_0001);
    high_count(1, n);
    chk(32'(n), 32'd20);
    high_count(2, n);
    chk(32'(n), 32'd50);
    high_count(0, n);
    chk(32'(n), 32'd0);
    // Interrupt raised, masked and enabled
    bus_rd(`MPWM_A_IRQST, rdat);
    chk(rdat & 32'h0000_0001, 32'h0000_0001);
    chk({31'h0, irq}, 32'h0000_0000);
    bus_wr(`MPWM_A_IRQEN, 32'h0000_0001);
    @(negedge clock);
    chk({31'h0, irq}, 32'h0000_0001);
    // Period and duties rewritten together right after a master interrupt
    bus_wr(`MPWM_A_IRQCLR, 32'h0000_0001);
    @(posedge clock);
    while (irq !== 1'b1) @(posedge clock);
    bus_wr(`MPWM_A_DATA0, 32'h0000_0004);
    bus_wr(`MPWM_A_DATA0 + 8'h04, 32'h0000_0003);
    bus_wr(`MPWM_A_DATA0 + 8'h08, 32'h0000_0007);
    high_count(1, n);
    chk(32'(n), 32'd30);
    bus_wr(`MPWM_A_STOP, 32'h0000_0007);
    rd_chk(`MPWM_A_STATUS, 32'h0000_0000);
    bus_wr(`MPWM_A_IRQCLR, 32'h0000_0007);
    rd_chk(`MPWM_A_IRQST, 32'h0000_0000);
    @(negedge clock);
    chk({31'h0, irq}, 32'h0000_0000);
    // Power off again: registers cleared, pins released
    bus_wr(`MPWM_A_PWR, 32'h0000_0000);
    bus_wr(`MPWM_A_OUTEN, 32'h0000_0007);
    rd_chk(`MPWM_A_OUTEN, 32'h0000_0000);
    pins_chk(6'b000000);
    complete_run();
  end
endmodule
